//--- logic/wdt_top.sv
// Watchdog timer top: Wishbone register file, key protection, counter, reset/NMI output.
// Assumes source ticks and debug flag are synchronous one-cycle enables / levels on clk_i.
module wdt_top
	import wdt_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [ADDR_W-1:0] wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic [3:0]        src_tick_i,
	input  wire logic              cpu_debug_i,
	output logic                   sys_reset_o,
	output logic                   nmi_o,
	output logic                   irq_o
);
	logic [15:0]      protect_key_field_reg;
	logic [1:0]       counter_source_select_reg;
	logic [1:0]       counter_divider_select_reg;
	logic             debug_keep_running_reg;
	logic             timeout_action_select_reg;
	logic             timeout_nmi_flag_reg;
	logic [3:0]       run_stop_key_reg;
	logic [CNT_W-1:0] count_reg;
	logic [IRQ_W-1:0] irq_status_reg;
	logic [IRQ_W-1:0] irq_mask_reg;
	logic [31:0]      rd_data;
	wire              access;
	wire              wr;
	wire              wr_lo;
	wire              wr_hi;
	wire              unlocked;
	wire              hit_protect;
	wire              hit_cfg;
	wire              hit_ctl;
	wire              hit_status;
	wire              counter_clear;
	wire              running;
	wire              gate;
	wire              tick;
	wire              overflow;
	wire [IRQ_W-1:0]  irq_events;
	wire [3:0]        run_read;

	assign access      = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr          = access && wb_we_i;
	assign wr_lo       = wr && wb_sel_i[0];
	assign wr_hi       = wr && wb_sel_i[1];
	assign hit_protect = (wb_adr_i == OFS_PROTECT) && (OFS_PROTECT == 4'h0);
	assign hit_cfg     = (wb_adr_i == OFS_CLOCK_CFG);
	assign hit_ctl     = (wb_adr_i == OFS_CONTROL);
	assign hit_status  = (wb_adr_i == OFS_IRQ_STATUS);
	assign unlocked    = (protect_key_field_reg == PROTECT_UNLOCK);
	assign counter_clear = unlocked && hit_ctl && wr_lo && wb_dat_i[CTL_CLR_BIT];
	assign running     = (run_stop_key_reg != RUN_STOP_VALUE);
	assign gate        = running && (debug_keep_running_reg || !cpu_debug_i);
	assign overflow    = tick && (count_reg == {CNT_W{1'b1}}) && !counter_clear;
	assign irq_events  = {overflow && timeout_action_select_reg, overflow};
	assign run_read    = running ? RUN_READ_VALUE : run_stop_key_reg;

	always_comb begin
		rd_data = 32'h0000_0000;
		if (hit_protect)
			rd_data[15:0] = protect_key_field_reg;
		else if (hit_cfg) begin
			rd_data[CFG_SRC_LSB +: 2] = counter_source_select_reg;
			rd_data[CFG_DIV_LSB +: 2] = counter_divider_select_reg;
			rd_data[CFG_DBG_BIT]      = debug_keep_running_reg;
		end else if (hit_ctl) begin
			rd_data[CTL_RUN_LSB +: 4]  = run_read;
			rd_data[CTL_NMI_FLAG]      = timeout_nmi_flag_reg;
			rd_data[CTL_ACTION_BIT]    = timeout_action_select_reg;
		end else if (hit_status) begin
			rd_data[IRQ_W-1:0]      = irq_status_reg;
			rd_data[16 +: IRQ_W]    = irq_mask_reg;
		end
	end

	wdt_prescaler u_prescaler (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.src_tick_i (src_tick_i),
		.src_sel_i  (counter_source_select_reg),
		.div_sel_i  (counter_divider_select_reg),
		.gate_i     (gate),
		.tick_o     (tick)
	);

	// Bus slave: one wait state, unmapped reads return zero, writes ignored
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= access;
			wb_dat_o <= access ? rd_data : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			protect_key_field_reg <= 16'h0000;
		end else if (hit_protect) begin
			if (wr_lo)
				protect_key_field_reg[7:0] <= wb_dat_i[7:0];
			if (wr_hi)
				protect_key_field_reg[15:8] <= wb_dat_i[15:8];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			counter_source_select_reg  <= 2'h0;
			counter_divider_select_reg <= 2'h0;
			debug_keep_running_reg     <= 1'b0;
		end else if (unlocked && hit_cfg) begin
			if (wr_lo) begin
				counter_source_select_reg  <= wb_dat_i[CFG_SRC_LSB +: 2];
				counter_divider_select_reg <= wb_dat_i[CFG_DIV_LSB +: 2];
			end
			if (wr_hi)
				debug_keep_running_reg <= wb_dat_i[CFG_DBG_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_stop_key_reg          <= RUN_STOP_VALUE;
			timeout_action_select_reg <= 1'b0;
		end else if (unlocked && hit_ctl) begin
			if (wr_lo)
				run_stop_key_reg <= wb_dat_i[CTL_RUN_LSB +: 4];
			if (wr_hi)
				timeout_action_select_reg <= wb_dat_i[CTL_ACTION_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			count_reg <= '0;
		else if (counter_clear)
			count_reg <= '0;
		else if (tick)
			count_reg <= count_reg + CNT_W'(1);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sys_reset_o <= 1'b0;
			nmi_o       <= 1'b0;
		end else begin
			sys_reset_o <= overflow && !timeout_action_select_reg;
			nmi_o       <= overflow && timeout_action_select_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			timeout_nmi_flag_reg <= 1'b0;
		else if (overflow && timeout_action_select_reg)
			timeout_nmi_flag_reg <= 1'b1;
		else if (counter_clear)
			timeout_nmi_flag_reg <= 1'b0;
	end

	// Sticky status, write one clears, new event wins over the clear
	genvar gi;
	generate
		for (gi = 0; gi < IRQ_W; gi++) begin : g_irq
			always_ff @(posedge clk_i) begin
				if (rst_i)
					irq_status_reg[gi] <= 1'b0;
				else if (irq_events[gi])
					irq_status_reg[gi] <= 1'b1;
				else if (wr_lo && hit_status && wb_dat_i[gi])
					irq_status_reg[gi] <= 1'b0;
			end
			always_ff @(posedge clk_i) begin
				if (rst_i)
					irq_mask_reg[gi] <= 1'b0;
				else if (wr && wb_sel_i[2] && hit_status)
					irq_mask_reg[gi] <= wb_dat_i[16 + gi];
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(irq_status_reg & irq_mask_reg);
	end
endmodule : wdt_top

//--- logic/wdt_pkg.sv
// Package for the watchdog timer: register map, field layout, reset values, counts.
// Assumes a classic Wishbone slave with 32-bit data and word-aligned registers.
package wdt_pkg;
	localparam int          ADDR_W          = 4;
	localparam logic [3:0]  OFS_PROTECT     = 4'h0;
	localparam logic [3:0]  OFS_CLOCK_CFG   = 4'h4;
	localparam logic [3:0]  OFS_CONTROL     = 4'h8;
	localparam logic [3:0]  OFS_IRQ_STATUS  = 4'hC;
	localparam logic [3:0]  OFS_IRQ_MASK    = 4'h0;
	localparam logic [15:0] PROTECT_UNLOCK  = 16'h0096;
	localparam logic [3:0]  RUN_STOP_VALUE  = 4'ha;
	localparam logic [3:0]  RUN_READ_VALUE  = 4'h0;
	localparam int          CNT_W           = 10;
	localparam int          PRESCALE_W      = 14;
	// Clock config fields
	localparam int          CFG_SRC_LSB     = 0;
	localparam int          CFG_DIV_LSB     = 4;
	localparam int          CFG_DBG_BIT     = 8;
	// Control fields
	localparam int          CTL_RUN_LSB     = 0;
	localparam int          CTL_CLR_BIT     = 4;
	localparam int          CTL_NMI_FLAG    = 8;
	localparam int          CTL_ACTION_BIT  = 9;
	// Interrupt status bits
	localparam int          IRQ_W           = 2;
	localparam int          IRQ_OVF_BIT     = 0;
	localparam int          IRQ_NMI_BIT     = 1;
	// Source select codes
	localparam logic [1:0]  SRC_DIRECT      = 2'h3;
	localparam logic [1:0]  SRC_FIXED128    = 2'h1;
	localparam int          FIXED_DIV_LOG2  = 7;
	localparam int          BASE_DIV_LOG2   = 11;
endpackage : wdt_pkg

//--- logic/wdt_prescaler.sv
// Counter clock prescaler: selects a source tick and divides it by a power of two.
// Assumes source ticks are one-cycle enables already on clk_i.
module wdt_prescaler
	import wdt_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [3:0] src_tick_i,
	input  wire logic [1:0] src_sel_i,
	input  wire logic [1:0] div_sel_i,
	input  wire logic       gate_i,
	output logic            tick_o
);
	logic [PRESCALE_W-1:0] div_reg;
	logic [PRESCALE_W-1:0] div_next;
	logic [PRESCALE_W-1:0] limit;
	wire                   src_tick;
	wire                   wrap;
	assign src_tick = src_tick_i[src_sel_i];
	// Ratio per source: direct, fixed 1/128, or 1/2048 scaled by the divider field
	assign limit = (src_sel_i == SRC_DIRECT) ? '0 :
		(src_sel_i == SRC_FIXED128) ? PRESCALE_W'((1 << FIXED_DIV_LOG2) - 1) :
		PRESCALE_W'((1 << (BASE_DIV_LOG2 + int'(div_sel_i))) - 1);
	assign wrap     = (div_reg >= limit);
	assign div_next = wrap ? '0 : div_reg + PRESCALE_W'(1);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_reg <= '0;
			tick_o  <= 1'b0;
		end else begin
			tick_o <= 1'b0;
			if (gate_i && src_tick) begin
				div_reg <= div_next;
				tick_o  <= wrap;
			end
		end
	end
endmodule : wdt_prescaler

//--- test/wdt_top_monitor.sv
// Checker for the watchdog top: bus answer and timeout pulses.
// Assumes it is bound to every wdt_top and sees its ports only.
module wdt_top_monitor
	import wdt_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic        sys_reset_o,
	input wire logic        nmi_o,
	input wire logic        irq_o
);
	default clocking @(posedge clk_i); endclocking
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// Counter restarts from zero, so no pulse can follow soon
	sequence s_quiet;
		(!sys_reset_o && !nmi_o) [*8];
	endsequence
	a_ack_after_take:
	assert property (disable iff (rst_i) s_take |=> wb_ack_o) else $error("ack late");
	a_ack_one_cycle:
	assert property (disable iff (rst_i) wb_ack_o |=> !wb_ack_o) else $error("ack long");
	a_dat_idle_zero:
	assert property (disable iff (rst_i) !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("dat not 0");
	a_reset_pulse_one:
	assert property (disable iff (rst_i) sys_reset_o |=> !sys_reset_o) else $error("rst long");
	a_nmi_pulse_one:
	assert property (disable iff (rst_i) $rose(nmi_o) |=> $fell(nmi_o)) else $error("nmi long");
	a_action_exclusive:
	assert property (disable iff (rst_i) !(sys_reset_o && nmi_o)) else $error("both actions");
	a_restart_quiet:
	assert property (disable iff (rst_i) (sys_reset_o || nmi_o) |=> s_quiet)
		else $error("early pulse");
	a_reset_outputs_low:
	assert property (rst_i |=> !sys_reset_o && !nmi_o && !irq_o) else $error("out in reset");
endmodule : wdt_top_monitor

bind wdt_top wdt_top_monitor u_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.wb_dat_o, .sys_reset_o, .nmi_o, .irq_o);

//--- test/wdt_clkgen_model.sv
// Clock generator stand-in: one-cycle source ticks on clk_i.
// Assumes reset shared with the watchdog; sources run from reset on.
module wdt_clkgen_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	output logic      [3:0] tick_o
);
	logic [6:0] div_reg;
	always_ff @(posedge clk_i) begin
		div_reg <= rst_i ? 7'h00 : div_reg + 7'h01;
	end
	assign tick_o = rst_i ? 4'h0 : {1'b1, div_reg == 7'h00, 1'b1, div_reg[0]};
endmodule : wdt_clkgen_model

//--- test/wdt_top_tb.sv
// Bench for the watchdog top: Wishbone driver, scoreboard, pulse timing.
// Assumes the direct source ticks every cycle, so a period is 1024 cycles.
module wdt_top_tb;
	import wdt_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, dbg = 1'b0;
	logic [3:0]  adr = 4'h0, sel = 4'h0, tick, run;
	logic [31:0] dat = 32'h0000_0000, dat_o, x = 32'h0000_0009, exp_q[$];
	logic        ack, sr, nmi, irq;
	logic [1:0]  pq[$];
	int          failures = 0, cmp_count = 0, cyc_cnt = 0;
	always #25 clk_i = ~clk_i;
	wdt_clkgen_model i_gen (.clk_i, .rst_i, .tick_o(tick));
	wdt_top i_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.src_tick_i(tick), .cpu_debug_i(dbg), .sys_reset_o(sr), .nmi_o(nmi), .irq_o(irq));
	function automatic logic [31:0] rnd();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : rnd
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic print_verdict();
		if (failures == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		{cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hf};
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		{cyc, stb} <= 2'b00;
		@(posedge clk_i);
	endtask : wb
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		wb(1'b0, a, 32'h0000_0000);
	endtask : rd
	// Waits for the next action pulse and checks how many cycles it took
	task automatic wp(input logic [1:0] k, input int lo, input int hi);
		int n = 0;
		pq.push_back(k);
		do begin
			@(posedge clk_i);
			n++;
		end while (!(sr | nmi));
		chk("period", 32'(n >= lo && n <= hi), 32'h1);
	endtask : wp
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt > 20000) begin
			failures++;
			print_verdict();
		end
		if (ack && !we) chk("rdata", dat_o, exp_q.pop_front());
		if (sr | nmi) chk("action", {30'h0, nmi, sr}, {30'h0, pq.pop_front()});
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(OFS_CONTROL, 32'h0000_000a);
		wb(1'b1, OFS_PROTECT, 32'h0000_0096);
		wb(1'b1, OFS_CLOCK_CFG, 32'h0000_0003);
		rd(OFS_CLOCK_CFG, 32'h0000_0003);
		run = 4'(rnd());
		if (run == RUN_STOP_VALUE) run = 4'h5;
		wb(1'b1, OFS_CONTROL, {27'h0, 1'b1, run});
		rd(OFS_CONTROL, 32'h0000_0000);
		wb(1'b1, OFS_PROTECT, rnd() & 32'h0000_ff00);
		// Stop while locked must be ignored
		wb(1'b1, OFS_CONTROL, 32'h0000_000a);
		wp(2'b01, 1000, 1030);
		wp(2'b01, 1024, 1024);
		wb(1'b1, OFS_PROTECT, 32'h0000_0096);
		repeat (2) begin
			repeat (700) @(posedge clk_i);
			wb(1'b1, OFS_CONTROL, 32'h0000_0015);
		end
		wb(1'b1, OFS_CONTROL, 32'h0000_0215);
		wp(2'b10, 1000, 1030);
		rd(OFS_CONTROL, 32'h0000_0300);
		rd(OFS_IRQ_STATUS, 32'h0000_0003);
		chk("irq", {31'h0, irq}, 32'h0);
		wb(1'b1, OFS_IRQ_STATUS, 32'h0003_0000);
		@(negedge clk_i);
		chk("irq", {31'h0, irq}, 32'h1);
		@(posedge clk_i);
		wb(1'b1, OFS_IRQ_STATUS, 32'h0003_0003);
		@(negedge clk_i);
		chk("irq", {31'h0, irq}, 32'h0);
		@(posedge clk_i);
		wb(1'b1, OFS_CONTROL, 32'h0000_021a);
		rd(OFS_CONTROL, 32'h0000_020a);
		wb(1'b1, OFS_CONTROL, 32'h0000_0015);
		repeat (200) @(posedge clk_i);
		dbg <= 1'b1;
		repeat (1500) @(posedge clk_i);
		dbg <= 1'b0;
		wp(2'b01, 800, 830);
		wb(1'b1, OFS_CLOCK_CFG, 32'h0000_0103);
		wb(1'b1, OFS_CONTROL, 32'h0000_0015);
		dbg <= 1'b1;
		wp(2'b01, 1000, 1030);
		print_verdict();
	end
endmodule : wdt_top_tb
